/* src/timer_pwm_start_bus_access.sv */
// control slice: pwm select, counter run control and cpu byte/word access
// assumes the cpu bus is synchronous to CLK with one-cycle strobes
//
// Function
// - channel 3 select bit set gives two-phase pwm; reset clears it
// - channel 3 pwm mode ignores both general output level pairs
// - channel 2 select bit set gives two-phase pwm; reset clears it
// - channel 2 pwm mode ignores its four general output bits
// - channel 1 select bit set gives three-phase pwm; reset clears it
// - channel 1 pwm mode ignores dedicated pair and both general pairs
// - start register bits 6..0 run channels 7..1, reset to zero
// - start register bit 7 is read-only and reads as one
// - counter, general and dedicated registers take whole 16-bit accesses
// - those 16-bit registers accept upper or lower byte access alone
// - control, status, enable, mode and start registers are byte registers
// - word access to byte registers is upper even byte then lower odd
// - word pairs: control, status, enable with mode, start with ch1 control b
// - setting a start bit makes that counter begin from zero unless a word write to that counter comes in the same cycle
// - mode b top two bits are read-only and read as one
`timescale 1ns/1ps
module timer_pwm_start_bus_access (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic BYTE_WR,
    input wire logic BYTE_RD,
    input wire logic [2:0] BYTE_CH,
    input wire logic [3:0] BYTE_SEL,
    input wire logic [7:0] BYTE_WDATA,
    output logic [7:0] BYTE_RDATA,
    input wire logic WORD_WR,
    input wire logic WORD_RD,
    input wire logic [2:0] WORD_CH,
    input wire logic [2:0] WORD_SEL,
    input wire logic [1:0] WORD_BE,
    input wire logic [15:0] WORD_WDATA,
    output logic [15:0] WORD_RDATA,
    input wire logic [6:0] COUNT_TICK,
    input wire logic [6:0] STATUS_HI_IN,
    input wire logic [6:0] STATUS_LO_IN,
    output logic [6:0] RUN,
    output logic [6:0] COUNT_CLEAR,
    output logic CH1_PWM,
    output logic CH2_PWM,
    output logic CH3_PWM,
    output logic [7:0] CH1_OE_EFF,
    output logic [7:0] CH2_OE_EFF,
    output logic [7:0] CH3_OE_EFF
);
    import tpu_ctl_pkg::*;

    logic [7:0] start_ff;
    logic [7:0] mode_b_ff;
    logic [7:0] ch1_ctrl_b_ff;
    logic [7:0] ctrl_hi_ff [NUM_CH];
    logic [7:0] ctrl_lo_ff [NUM_CH];
    logic [7:0] stat_hi_ff [NUM_CH];
    logic [7:0] stat_lo_ff [NUM_CH];
    logic [7:0] oe_ff [NUM_CH];
    logic [15:0] cnt_ff [NUM_CH];
    logic [15:0] gen1_ff [NUM_CH];
    logic [15:0] gen2_ff [NUM_CH];
    logic [15:0] ded1_ff [NUM_CH];
    logic [15:0] ded2_ff [NUM_CH];
    logic [7:0] nxt_start;
    logic [7:0] nxt_mode_b;
    logic [6:0] start_rise;

    function automatic logic [15:0] merge_word(input logic [15:0] old_v,
        input logic [15:0] new_v, input logic [1:0] be);
        merge_word = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    function automatic logic ch_ok(input logic [2:0] ch);
        ch_ok = ch < 3'(NUM_CH);
    endfunction

    function automatic logic byte_hit(input logic [3:0] sel);
        byte_hit = BYTE_WR && ch_ok(BYTE_CH) && (BYTE_SEL == sel);
    endfunction

    function automatic logic word_hit(input logic [2:0] sel);
        word_hit = WORD_WR && ch_ok(WORD_CH) && (WORD_SEL == sel);
    endfunction

    function automatic logic [7:0] force_ro(input logic [7:0] v, input logic [7:0] mask);
        force_ro = (v & ~mask) | mask;
    endfunction

    function automatic logic [7:0] mask_oe(input logic pwm, input logic [7:0] oe,
        input logic [7:0] mask);
        mask_oe = pwm ? (oe & ~mask) : oe;
    endfunction

    always_comb begin
        nxt_start = start_ff;
        if (byte_hit(SEL_START)) begin
            nxt_start = force_ro(BYTE_WDATA, START_RO_MASK);
        end
    end

    always_comb begin
        nxt_mode_b = mode_b_ff;
        if (byte_hit(SEL_MODE)) begin
            nxt_mode_b = force_ro(BYTE_WDATA, MODE_B_RO_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            start_ff <= START_RESET;
        end else begin
            start_ff <= nxt_start;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            mode_b_ff <= MODE_B_RESET;
        end else begin
            mode_b_ff <= nxt_mode_b;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_hi_ff[i] <= CTRL_RESET;
                ctrl_lo_ff[i] <= CTRL_RESET;
            end
        end else if (BYTE_WR && ch_ok(BYTE_CH)) begin
            case (BYTE_SEL)
                SEL_CTRL_HI: ctrl_hi_ff[BYTE_CH] <= BYTE_WDATA;
                SEL_CTRL_LO: ctrl_lo_ff[BYTE_CH] <= BYTE_WDATA;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                oe_ff[i] <= OE_RESET;
            end
        end else if (byte_hit(SEL_OE)) begin
            oe_ff[BYTE_CH] <= BYTE_WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ch1_ctrl_b_ff <= CTRL_RESET;
        end else if (byte_hit(SEL_CH1_CTRL_B)) begin
            ch1_ctrl_b_ff <= BYTE_WDATA;
        end
    end

    // status high mirrors channel flags
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                stat_hi_ff[i] <= CTRL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                stat_hi_ff[i] <= {1'b0, STATUS_HI_IN};
            end
        end
    end

    // status low mirrors channel flags
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                stat_lo_ff[i] <= CTRL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                stat_lo_ff[i] <= {1'b0, STATUS_LO_IN};
            end
        end
    end

    assign start_rise = nxt_start[6:0] & ~start_ff[6:0];
    assign COUNT_CLEAR = start_rise;
    assign RUN = start_ff[6:0];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cnt_ff[i] <= CNT_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (start_rise[i]) begin
                    cnt_ff[i] <= CNT_RESET;
                end else if (start_ff[i] && COUNT_TICK[i]) begin
                    cnt_ff[i] <= cnt_ff[i] + 16'h0001;
                end
            end
            if (word_hit(WSEL_CNT)) begin
                cnt_ff[WORD_CH] <= merge_word(cnt_ff[WORD_CH], WORD_WDATA, WORD_BE);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NUM_CH; i++) begin
                gen1_ff[i] <= CNT_RESET;
                gen2_ff[i] <= CNT_RESET;
                ded1_ff[i] <= CNT_RESET;
                ded2_ff[i] <= CNT_RESET;
            end
        end else if (WORD_WR && ch_ok(WORD_CH)) begin
            case (WORD_SEL)
                WSEL_GEN1: gen1_ff[WORD_CH] <= merge_word(gen1_ff[WORD_CH], WORD_WDATA, WORD_BE);
                WSEL_GEN2: gen2_ff[WORD_CH] <= merge_word(gen2_ff[WORD_CH], WORD_WDATA, WORD_BE);
                WSEL_DED1: ded1_ff[WORD_CH] <= merge_word(ded1_ff[WORD_CH], WORD_WDATA, WORD_BE);
                WSEL_DED2: ded2_ff[WORD_CH] <= merge_word(ded2_ff[WORD_CH], WORD_WDATA, WORD_BE);
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            BYTE_RDATA <= 8'h00;
        end else if (BYTE_RD) begin
            BYTE_RDATA <= 8'h00;
            if (ch_ok(BYTE_CH)) begin
                case (BYTE_SEL)
                    SEL_CTRL_HI: BYTE_RDATA <= ctrl_hi_ff[BYTE_CH];
                    SEL_CTRL_LO: BYTE_RDATA <= ctrl_lo_ff[BYTE_CH];
                    SEL_STAT_HI: BYTE_RDATA <= stat_hi_ff[BYTE_CH];
                    SEL_STAT_LO: BYTE_RDATA <= stat_lo_ff[BYTE_CH];
                    SEL_OE: BYTE_RDATA <= oe_ff[BYTE_CH];
                    SEL_MODE: BYTE_RDATA <= mode_b_ff;
                    SEL_START: BYTE_RDATA <= start_ff;
                    SEL_CH1_CTRL_B: BYTE_RDATA <= ch1_ctrl_b_ff;
                    default: BYTE_RDATA <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            WORD_RDATA <= 16'h0000;
        end else if (WORD_RD) begin
            WORD_RDATA <= 16'h0000;
            if (ch_ok(WORD_CH)) begin
                case (WORD_SEL)
                    WSEL_CNT: WORD_RDATA <= merge_word(16'h0000, cnt_ff[WORD_CH], WORD_BE);
                    WSEL_GEN1: WORD_RDATA <= merge_word(16'h0000, gen1_ff[WORD_CH], WORD_BE);
                    WSEL_GEN2: WORD_RDATA <= merge_word(16'h0000, gen2_ff[WORD_CH], WORD_BE);
                    WSEL_DED1: WORD_RDATA <= merge_word(16'h0000, ded1_ff[WORD_CH], WORD_BE);
                    WSEL_DED2: WORD_RDATA <= merge_word(16'h0000, ded2_ff[WORD_CH], WORD_BE);
                    default: WORD_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    assign CH1_PWM = mode_b_ff[MODE_CH1_PWM];
    assign CH2_PWM = mode_b_ff[MODE_CH2_PWM];
    assign CH3_PWM = mode_b_ff[MODE_CH3_PWM];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            CH1_OE_EFF <= OE_RESET;
        end else begin
            CH1_OE_EFF <= mask_oe(CH1_PWM, oe_ff[0], CH2_PULSE_MODE_SEL_OE_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            CH2_OE_EFF <= OE_RESET;
        end else begin
            CH2_OE_EFF <= mask_oe(CH2_PWM, oe_ff[1], PWM23_OE_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            CH3_OE_EFF <= OE_RESET;
        end else begin
            CH3_OE_EFF <= mask_oe(CH3_PWM, oe_ff[2], PWM23_OE_MASK);
        end
    end
endmodule

/* src/tpu_ctl_pkg.sv */
// constants for the timer pulse unit control slice
// assumes a single system clock and a synchronous active-high reset
package tpu_ctl_pkg;
    localparam int NUM_CH = 7;
    localparam logic [7:0] START_RESET = 8'h80;
    localparam logic [7:0] MODE_B_RESET = 8'hc0;
    localparam logic [7:0] START_RO_MASK = 8'h80;
    localparam logic [7:0] MODE_B_RO_MASK = 8'hc0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OE_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // byte-bus register selects
    localparam logic [3:0] SEL_CTRL_HI = 4'h0;
    localparam logic [3:0] SEL_CTRL_LO = 4'h1;
    localparam logic [3:0] SEL_STAT_HI = 4'h2;
    localparam logic [3:0] SEL_STAT_LO = 4'h3;
    localparam logic [3:0] SEL_OE = 4'h4;
    localparam logic [3:0] SEL_MODE = 4'h5;
    localparam logic [3:0] SEL_START = 4'h6;
    localparam logic [3:0] SEL_CH1_CTRL_B = 4'h7;
    // word-bus register selects
    localparam logic [2:0] WSEL_CNT = 3'h0;
    localparam logic [2:0] WSEL_GEN1 = 3'h1;
    localparam logic [2:0] WSEL_GEN2 = 3'h2;
    localparam logic [2:0] WSEL_DED1 = 3'h3;
    localparam logic [2:0] WSEL_DED2 = 3'h4;
    // output enable register field positions
    localparam int OE_DED1_LO = 0;
    localparam int OE_DED1_HI = 1;
    localparam int OE_GEN1_LO = 2;
    localparam int OE_GEN1_HI = 3;
    localparam int OE_GEN2_LO = 4;
    localparam int OE_GEN2_HI = 5;
    // mode b field positions
    localparam int MODE_CH1_PWM = 0;
    localparam int MODE_CH2_PWM = 1;
    localparam int MODE_CH3_PWM = 2;
    localparam logic [7:0] CH2_PULSE_MODE_SEL_OE_MASK = 8'h3f;
    localparam logic [7:0] PWM23_OE_MASK = 8'h3c;
endpackage

/* sim/tpu_ctl_chk.sv */
// assertions on the control slice ports
// assumes a bind onto the top module
`timescale 1ns/1ps
module tpu_ctl_chk
    import tpu_ctl_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic BYTE_WR,
    input wire logic BYTE_RD,
    input wire logic [2:0] BYTE_CH,
    input wire logic [3:0] BYTE_SEL,
    input wire logic [7:0] BYTE_WDATA,
    input wire logic [7:0] BYTE_RDATA,
    input wire logic [6:0] RUN,
    input wire logic [6:0] COUNT_CLEAR,
    input wire logic CH1_PWM,
    input wire logic CH3_PWM,
    input wire logic [7:0] CH1_OE_EFF,
    input wire logic [7:0] CH3_OE_EFF
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic ok, sw, sr, mw, mr;
    assign ok = BYTE_CH != 3'h7;
    assign sw = BYTE_WR && BYTE_SEL == SEL_START && ok;
    assign sr = BYTE_RD && BYTE_SEL == SEL_START && ok;
    assign mw = BYTE_WR && BYTE_SEL == SEL_MODE && ok;
    assign mr = BYTE_RD && BYTE_SEL == SEL_MODE && ok;
    a_start_write: assert property (sw |=> RUN == $past(BYTE_WDATA[6:0]))
        else $error("run bits differ from start write");
    a_start_hold: assert property (!sw |=> $stable(RUN))
        else $error("run bits moved without a start write");
    a_start_bit7: assert property (sr |=> BYTE_RDATA == {1'b1, $past(RUN)})
        else $error("start read wrong");
    a_clear_pulse: assert property (COUNT_CLEAR == (sw ? BYTE_WDATA[6:0] & ~RUN : 7'h0))
        else $error("counter clear pulse wrong");
    a_mode_top: assert property (mr |=> BYTE_RDATA[7:6] == 2'b11)
        else $error("mode top bits not one");
    a_ch1_sel: assert property (mw |=> CH1_PWM == $past(BYTE_WDATA[0]))
        else $error("channel 1 pwm select wrong");
    a_ch3_sel: assert property (mw |=> CH3_PWM == $past(BYTE_WDATA[2]))
        else $error("channel 3 pwm select wrong");
    a_ch1_mask: assert property (CH1_PWM [*2] |-> (CH1_OE_EFF & CH2_PULSE_MODE_SEL_OE_MASK) == 8'h00)
        else $error("channel 1 enables not masked");
    a_ch3_mask: assert property (CH3_PWM [*2] |-> (CH3_OE_EFF & PWM23_OE_MASK) == 8'h00)
        else $error("channel 3 enables not masked");
    cover property (COUNT_CLEAR != 7'h0);
    cover property (CH1_PWM [*2]);
    cover property (sr);
endmodule
bind timer_pwm_start_bus_access tpu_ctl_chk i_tpu_ctl_chk (.*);

/* sim/cpu_host.sv */
// processor model driving the byte and word buses
// assumes the bench calls its tasks; strobes change at the falling edge
`timescale 1ns/1ps
module cpu_host (
    input wire logic clk,
    output logic bwr,
    output logic brd,
    output logic [2:0] bch,
    output logic [3:0] bsel,
    output logic [7:0] bwd,
    input wire logic [7:0] brdat,
    output logic wwr,
    output logic wrd,
    output logic [2:0] wch,
    output logic [2:0] wsel,
    output logic [1:0] wbe,
    output logic [15:0] wwd,
    input wire logic [15:0] wrdat
);
    initial begin
        {bwr, brd, bch, bsel, bwd, wwr, wrd, wch, wsel, wbe, wwd} = '0;
    end
    task automatic bacc(input logic w, input logic [2:0] c, input logic [3:0] s,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        {bwr, brd, bch, bsel, bwd} = {w, !w, c, s, d};
        @(negedge clk);
        {bwr, brd, bwd} = {2'b00, ~d};
        q = brdat;
    endtask
    task automatic wacc(input logic w, input logic [2:0] c, input logic [2:0] s,
        input logic [1:0] e, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        {wwr, wrd, wch, wsel, wbe, wwd} = {w, !w, c, s, e, d};
        @(negedge clk);
        {wwr, wrd, wwd} = {2'b00, ~d};
        q = wrdat;
    endtask
    task automatic pair(input logic w, input logic [2:0] c, input logic [3:0] s,
        input logic [15:0] d, output logic [15:0] q);
        bacc(w, c, s, d[15:8], q[15:8]);
        bacc(w, c, s + 4'h1, d[7:0], q[7:0]);
    endtask
endmodule

/* sim/tb.sv */
// testbench for the control slice
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb;
    import tpu_ctl_pkg::*;
    logic clk, rst, bwr, brd, wwr, wrd, p1, p2, p3;
    logic [2:0] bch, wch, wsel;
    logic [3:0] bsel;
    logic [1:0] wbe;
    logic [7:0] bwd, brdat, q8, oe1, oe2, oe3;
    logic [15:0] wwd, wrdat, q16;
    logic [6:0] tick, sh, sl, run, clr;
    int err_total = 0;
    int checks = 0;
    cpu_host i_cpu_host (.*);
    timer_pwm_start_bus_access i_timer_pwm_start_bus_access (.CLK(clk), .RESET(rst),
        .BYTE_WR(bwr), .BYTE_RD(brd), .BYTE_CH(bch), .BYTE_SEL(bsel), .BYTE_WDATA(bwd),
        .BYTE_RDATA(brdat), .WORD_WR(wwr), .WORD_RD(wrd), .WORD_CH(wch), .WORD_SEL(wsel),
        .WORD_BE(wbe), .WORD_WDATA(wwd), .WORD_RDATA(wrdat), .COUNT_TICK(tick),
        .STATUS_HI_IN(sh), .STATUS_LO_IN(sl), .RUN(run), .COUNT_CLEAR(clr),
        .CH1_PWM(p1), .CH2_PWM(p2), .CH3_PWM(p3), .CH1_OE_EFF(oe1), .CH2_OE_EFF(oe2),
        .CH3_OE_EFF(oe3));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bw(input logic [2:0] c, input logic [3:0] s, input logic [7:0] d);
        i_cpu_host.bacc(1'b1, c, s, d, q8);
    endtask
    task automatic brc(input logic [2:0] c, input logic [3:0] s, input logic [7:0] e);
        i_cpu_host.bacc(1'b0, c, s, 8'h00, q8);
        chk({8'h00, q8}, {8'h00, e});
    endtask
    task automatic ww(input logic [2:0] c, input logic [2:0] s, input logic [1:0] b,
        input logic [15:0] d);
        i_cpu_host.wacc(1'b1, c, s, b, d, q16);
    endtask
    task automatic wrc(input logic [2:0] c, input logic [2:0] s, input logic [1:0] b,
        input logic [15:0] e);
        i_cpu_host.wacc(1'b0, c, s, b, 16'h0000, q16);
        chk(q16, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_start;
        brc(3'h0, SEL_START, 8'h80);
        ww(3'h0, WSEL_CNT, 2'h3, 16'h1234);
        bw(3'h0, SEL_START, 8'h01);
        wrc(3'h0, WSEL_CNT, 2'h3, 16'h0000);
        @(negedge clk) tick = 7'h01;
        repeat (5) @(negedge clk);
        tick = 7'h00;
        wrc(3'h0, WSEL_CNT, 2'h3, 16'h0005);
        bw(3'h0, SEL_START, 8'hff);
        chk({9'h0, run}, 16'h007f);
        bw(3'h0, SEL_START, 8'h00);
        brc(3'h0, SEL_START, 8'h80);
        $display("start test done");
    endtask
    task automatic t_mode;
        brc(3'h0, SEL_MODE, 8'hc0);
        for (int i = 0; i < 3; i++) bw(i[2:0], SEL_OE, 8'h3f);
        bw(3'h0, SEL_MODE, 8'h07);
        brc(3'h0, SEL_MODE, 8'hc7);
        chk({p3, p2, p1, oe1, oe2[4:0]}, 16'he003);
        chk({8'h00, oe3}, 16'h0003);
        bw(3'h0, SEL_MODE, 8'h00);
        brc(3'h0, SEL_MODE, 8'hc0);
        chk({oe1, oe2}, 16'h3f3f);
        chk({p3, oe3}, 16'h003f);
        $display("mode test done");
    endtask
    task automatic t_bus;
        ww(3'h1, WSEL_GEN1, 2'h3, 16'ha55a);
        wrc(3'h1, WSEL_GEN1, 2'h3, 16'ha55a);
        ww(3'h1, WSEL_GEN1, 2'h2, 16'h3c00);
        wrc(3'h1, WSEL_GEN1, 2'h3, 16'h3c5a);
        ww(3'h1, WSEL_GEN1, 2'h1, 16'hffc3);
        wrc(3'h1, WSEL_GEN1, 2'h1, 16'h00c3);
        i_cpu_host.pair(1'b1, 3'h0, SEL_OE, 16'h15c5, q16);
        i_cpu_host.pair(1'b0, 3'h0, SEL_OE, 16'h0000, q16);
        chk(q16, 16'h15c5);
        {sh, sl} = {7'h55, 7'h2a};
        i_cpu_host.pair(1'b0, 3'h2, SEL_STAT_HI, 16'h0000, q16);
        chk(q16, 16'h552a);
        i_cpu_host.pair(1'b1, 3'h3, SEL_CTRL_HI, 16'h5aa5, q16);
        i_cpu_host.pair(1'b0, 3'h3, SEL_CTRL_HI, 16'h0000, q16);
        chk(q16, 16'h5aa5);
        i_cpu_host.pair(1'b1, 3'h0, SEL_START, 16'h0066, q16);
        i_cpu_host.pair(1'b0, 3'h0, SEL_START, 16'h0000, q16);
        chk(q16, 16'h8066);
        bw(3'h7, SEL_START, 8'h7f);
        brc(3'h0, SEL_START, 8'h80);
        ww(3'h6, WSEL_GEN2, 2'h3, 16'h0f0f);
        ww(3'h6, WSEL_DED1, 2'h3, 16'hf00f);
        ww(3'h6, WSEL_DED2, 2'h2, 16'h77ff);
        wrc(3'h6, WSEL_GEN2, 2'h3, 16'h0f0f);
        wrc(3'h6, WSEL_DED1, 2'h3, 16'hf00f);
        wrc(3'h6, WSEL_DED2, 2'h3, 16'h7700);
        $display("bus test done");
    endtask
    task automatic t_reset;
        bw(3'h0, SEL_START, 8'h03);
        tick = 7'h01;
        bw(3'h0, SEL_MODE, 8'h07);
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk({9'h0, run}, 16'h0000);
        chk({13'h0, p3, p2, p1}, 16'h0000);
        brc(3'h0, SEL_START, 8'h80);
        brc(3'h0, SEL_MODE, 8'hc0);
        wrc(3'h0, WSEL_CNT, 2'h3, 16'h0000);
        tick = 7'h00;
        $display("reset test done");
    endtask
    initial begin
        {rst, tick, sh, sl} = {1'b1, 21'h0};
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_start;
        t_mode;
        t_bus;
        t_reset;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up;
    end
endmodule
